/* File: rtl/mlb_defs.vh */
// Purpose: constants for the multiplexed local bus strobe block
// Assumes: 100 MHz system clock, 20-bit cpu address
// Notes:   register offsets are byte addresses on the plain register port
`ifndef MLB_DEFS_VH
`define MLB_DEFS_VH
// =====================================================================
// register offsets
`define MLB_REG_MODE      4'h0
`define MLB_REG_WAIT      4'h1
`define MLB_REG_STATUS    4'h2
// =====================================================================
// mode register fields
`define MLB_MODE_EXP_LO   0
`define MLB_MODE_EXP_HI   1
`define MLB_MODE_RELOC    2
`define MLB_MODE_BUSTYPE  3
`define MLB_MODE_RESET    8'h00
// expansion mode codes
`define MLB_EXP_SINGLE    2'h0
`define MLB_EXP_256K      2'h1
`define MLB_EXP_1M        2'h2
// =====================================================================
// wait register fields
`define MLB_WAIT_LO       0
`define MLB_WAIT_HI       1
`define MLB_WAIT_RESET    8'h02
`define MLB_WAIT_EXT      2'h3
// =====================================================================
// address map
`define MLB_ROM_END_A     20'h17fff
`define MLB_ROM_END_B     20'h1ffff
`define MLB_INT_LO_BASE   20'h0df00
`define MLB_INT_LO_END    20'h0ffff
`define MLB_INT_HI_BASE   20'hfdf00
`define MLB_INT_HI_END    20'hfffff
`define MLB_XSFR_LO_BASE  20'h0ffd0
`define MLB_XSFR_LO_END   20'h0ffdf
`define MLB_XSFR_HI_BASE  20'hfffd0
`define MLB_XSFR_HI_END   20'hfffdf
`define MLB_MASK_256K     20'h3ffff
// =====================================================================
// timing
`define MLB_BASE_CYCLES   3'h3
`endif

/* File: rtl/mlb_map.v */
// Purpose: decode a cpu address into internal or external space
// Assumes: 20-bit address, combinational
// Notes:   external sfr window always goes out in expansion mode
`timescale 1ns/1ns
`default_nettype none
`include "mlb_defs.vh"
module mlb_map (
	input  wire [19:0] i_addr,
	input  wire [1:0]  i_exp_mode,
	input  wire        i_reloc,
	input  wire        i_rom_big,
	output wire        o_external
);
	wire [19:0] rom_end;
	wire        in_rom;
	wire        in_int;
	wire        in_xsfr;
	wire        expanded;
	assign rom_end  = i_rom_big ? `MLB_ROM_END_B : `MLB_ROM_END_A;
	// internal rom sits at the bottom; with low map_relocate_instr ram/sfr cut out below 0ffffh
	assign in_rom   = (i_addr <= rom_end) &&
		!(!i_reloc && (i_addr >= `MLB_INT_LO_BASE) && (i_addr <= `MLB_INT_LO_END));
	// low or high placement of sfr and ram
	assign in_int   = i_reloc ?
		((i_addr >= `MLB_INT_HI_BASE) && (i_addr <= `MLB_INT_HI_END)) :
		((i_addr >= `MLB_INT_LO_BASE) && (i_addr <= `MLB_INT_LO_END));
	assign in_xsfr  = i_reloc ?
		((i_addr >= `MLB_XSFR_HI_BASE) && (i_addr <= `MLB_XSFR_HI_END)) :
		((i_addr >= `MLB_XSFR_LO_BASE) && (i_addr <= `MLB_XSFR_LO_END));
	assign expanded = (i_exp_mode == `MLB_EXP_256K) || (i_exp_mode == `MLB_EXP_1M);
	// in 256k or 1m expansion mode, anything else above rom end goes external
	assign o_external = expanded && ((!in_rom && !in_int) || in_xsfr);
endmodule
`default_nettype wire

/* File: rtl/mlb_top.v */
// Purpose: multiplexed local bus strobe and pin sequencer
// Assumes: cpu request is a one-cycle pulse, held off while o_busy is high
// Notes:   separate bus type only recorded; sequencing is multiplexed
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "mlb_defs.vh"
// How it works
// - read strobe low on external fetch/read
// - read strobe high on internal access
// - write strobe low only external writes
// - write strobe high on internal access
// - wait input sampled only when external
// - wait pin free as port otherwise
// - address strobe pulses on external access
// - address strobe low on internal access
// - drive address, write data; capture read
// - pins hold value on internal access
// - low map_relocate_instr: internal at 0ffffh top
// - high map_relocate_instr: internal at fffffh top
// - other space above rom goes external in 256k or 1m expansion mode
// - bus type bit resets to multiplexed
// - wait field: 0/1/2 waits or external
// - 256k mode masks upper address bits
module mlb_top (
	input  wire        i_clk_sys,
	input  wire        i_reset_n,
	input  wire [3:0]  i_reg_addr,
	input  wire [7:0]  i_reg_wdata,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	output reg  [7:0]  o_reg_rdata,
	input  wire        i_rom_big,
	input  wire        i_cpu_req,
	input  wire        i_cpu_write,
	input  wire [19:0] i_cpu_addr,
	input  wire [7:0]  i_cpu_wdata,
	output reg         o_busy,
	output reg         o_cpu_done,
	output reg         o_cpu_ext,
	output reg  [7:0]  o_cpu_rdata,
	output reg         o_rd_n,
	output reg         o_wr_n,
	output reg         o_addr_latch_strobe,
	input  wire        i_wait_n,
	output reg         o_wait_pin_is_port,
	output reg  [7:0]  o_mux_addr_data_low_out,
	output reg         o_mux_addr_data_low_oe,
	input  wire [7:0]  i_mux_addr_data_low_in,
	output reg  [7:0]  o_addr_mid_byte,
	output reg  [3:0]  o_addr_top_nibble
);
	// =================================================================
	// state codes
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_ADDR = 5'b00010;
	localparam [4:0] ST_STRB = 5'b00100;
	localparam [4:0] ST_WAIT = 5'b01000;
	localparam [4:0] ST_LAST = 5'b10000;

	reg  [7:0]  mode_r;
	reg  [7:0]  wait_r;
	reg  [4:0]  state_r;
	reg  [4:0]  state_nxt;
	reg  [1:0]  wcnt_r;
	reg  [1:0]  wcnt_nxt;
	reg         write_r;
	reg  [7:0]  wdata_r;
	wire        ext_hit;
	wire [1:0]  wsel;
	wire [19:0] out_addr;
	wire        full_addr;
	wire [19:0] keep_mask;
	wire        sel_mode;
	wire        sel_wait;
	wire        sel_status;
	reg  [7:0]  rdata_nxt;
	reg         write_nxt;
	reg  [7:0]  wdata_nxt;
	reg         busy_nxt;
	reg         done_nxt;
	reg         ext_nxt;
	reg  [7:0]  cpu_rdata_nxt;
	reg         rd_n_nxt;
	reg         wr_n_nxt;
	reg         strobe_nxt;
	reg  [7:0]  ad_out_nxt;
	reg         ad_oe_nxt;
	reg  [7:0]  mid_nxt;
	reg  [3:0]  top_nxt;
	genvar      gb;

	assign wsel = {wait_r[`MLB_WAIT_HI], wait_r[`MLB_WAIT_LO]};

	mlb_map u_map (
		.i_addr     (i_cpu_addr),
		.i_exp_mode ({mode_r[`MLB_MODE_EXP_HI], mode_r[`MLB_MODE_EXP_LO]}),
		.i_reloc    (mode_r[`MLB_MODE_RELOC]),
		.i_rom_big  (i_rom_big),
		.o_external (ext_hit)
	);

	// upper bits cut unless 1m expansion
	assign full_addr = ({mode_r[`MLB_MODE_EXP_HI], mode_r[`MLB_MODE_EXP_LO]} == `MLB_EXP_1M);
	assign keep_mask = `MLB_MASK_256K;
	generate
		for (gb = 0; gb < 20; gb = gb + 1) begin : g_addr_mask
			assign out_addr[gb] = i_cpu_addr[gb] & (full_addr | keep_mask[gb]);
		end
	endgenerate

	// =================================================================
	// register port
	assign sel_mode   = (i_reg_addr == `MLB_REG_MODE);
	assign sel_wait   = (i_reg_addr == `MLB_REG_WAIT);
	assign sel_status = (i_reg_addr == `MLB_REG_STATUS);

	// read data stand one cycle, zero otherwise
	always @* begin
		rdata_nxt = 8'h00;
		if (i_reg_rd) begin
			if (sel_mode)
				rdata_nxt = mode_r;
			else if (sel_wait)
				rdata_nxt = wait_r;
			else if (sel_status)
				rdata_nxt = {3'h0, state_r};
		end
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_r <= `MLB_MODE_RESET;
			wait_r <= `MLB_WAIT_RESET;
		end else begin
			if (i_reg_wr && sel_mode)
				mode_r <= {4'h0, i_reg_wdata[3:0]};
			if (i_reg_wr && sel_wait)
				wait_r <= {6'h00, i_reg_wdata[1:0]};
		end
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n)
			o_reg_rdata <= 8'h00;
		else
			o_reg_rdata <= rdata_nxt;
	end

	// =================================================================
	// access sequencer
	always @* begin
		state_nxt = state_r;
		wcnt_nxt  = wcnt_r;
		case (state_r)
		ST_IDLE: begin
			if (i_cpu_req && ext_hit)
				state_nxt = ST_ADDR;
		end
		ST_ADDR: begin
			state_nxt = ST_STRB;
			wcnt_nxt  = (wsel == `MLB_WAIT_EXT) ? 2'h0 : wsel;
		end
		ST_STRB: begin
			if (wsel == `MLB_WAIT_EXT)
				state_nxt = ST_WAIT;
			else if (wcnt_r == 2'h0)
				state_nxt = ST_LAST;
			else
				wcnt_nxt = wcnt_r - 2'h1;
		end
		ST_WAIT: begin
			if (i_wait_n)
				state_nxt = ST_LAST;
		end
		ST_LAST: begin
			state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	// =================================================================
	// sequencer registers
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= ST_IDLE;
			wcnt_r  <= 2'h0;
		end else begin
			state_r <= state_nxt;
			wcnt_r  <= wcnt_nxt;
		end
	end

	// =================================================================
	// pin and response next values
	always @* begin
		// everything except done holds unless the sequencer moves it; done defaults low
		write_nxt     = write_r;
		wdata_nxt     = wdata_r;
		busy_nxt      = o_busy;
		done_nxt      = 1'b0;
		ext_nxt       = o_cpu_ext;
		cpu_rdata_nxt = o_cpu_rdata;
		rd_n_nxt      = o_rd_n;
		wr_n_nxt      = o_wr_n;
		strobe_nxt    = o_addr_latch_strobe;
		ad_out_nxt    = o_mux_addr_data_low_out;
		ad_oe_nxt     = o_mux_addr_data_low_oe;
		mid_nxt       = o_addr_mid_byte;
		top_nxt       = o_addr_top_nibble;
		case (state_r)
		ST_IDLE: begin
			if (i_cpu_req && !ext_hit) begin
				// internal: strobes idle, pins hold
				done_nxt = 1'b1;
				ext_nxt  = 1'b0;
			end else if (i_cpu_req) begin
				busy_nxt   = 1'b1;
				write_nxt  = i_cpu_write;
				wdata_nxt  = i_cpu_wdata;
				strobe_nxt = 1'b1;
				ad_out_nxt = out_addr[7:0];
				ad_oe_nxt  = 1'b1;
				mid_nxt    = out_addr[15:8];
				top_nxt    = out_addr[19:16];
			end
		end

		ST_ADDR: begin
			strobe_nxt = 1'b0;
			if (write_r) begin
				wr_n_nxt   = 1'b0;
				ad_out_nxt = wdata_r;
			end else begin
				rd_n_nxt  = 1'b0;
				ad_oe_nxt = 1'b0;
			end
		end

		ST_LAST: begin
			rd_n_nxt  = 1'b1;
			wr_n_nxt  = 1'b1;
			busy_nxt  = 1'b0;
			done_nxt  = 1'b1;
			ext_nxt   = 1'b1;
			ad_oe_nxt = 1'b0;
			if (!write_r)
				cpu_rdata_nxt = i_mux_addr_data_low_in;
		end

		default: begin
			strobe_nxt = 1'b0;
		end
		endcase
	end

	// =================================================================
	// every pin and response straight from a flop
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			write_r                 <= 1'b0;
			wdata_r                 <= 8'h00;
			o_busy                  <= 1'b0;
			o_cpu_done              <= 1'b0;
			o_cpu_ext               <= 1'b0;
			o_cpu_rdata             <= 8'h00;
			o_rd_n                  <= 1'b1;
			o_wr_n                  <= 1'b1;
			o_addr_latch_strobe     <= 1'b0;
			o_mux_addr_data_low_out <= 8'h00;
			o_mux_addr_data_low_oe  <= 1'b0;
			o_addr_mid_byte         <= 8'h00;
			o_addr_top_nibble       <= 4'h0;
		end else begin
			write_r                 <= write_nxt;
			wdata_r                 <= wdata_nxt;
			o_busy                  <= busy_nxt;
			o_cpu_done              <= done_nxt;
			o_cpu_ext               <= ext_nxt;
			o_cpu_rdata             <= cpu_rdata_nxt;
			o_rd_n                  <= rd_n_nxt;
			o_wr_n                  <= wr_n_nxt;
			o_addr_latch_strobe     <= strobe_nxt;
			o_mux_addr_data_low_out <= ad_out_nxt;
			o_mux_addr_data_low_oe  <= ad_oe_nxt;
			o_addr_mid_byte         <= mid_nxt;
			o_addr_top_nibble       <= top_nxt;
		end
	end

	// wait pin goes back to the port unless external wait is selected
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n)
			o_wait_pin_is_port <= 1'b1;
		else
			o_wait_pin_is_port <= (wsel != `MLB_WAIT_EXT);
	end
endmodule
`default_nettype wire

/* File: tb/mlb_top_props.sv */
// Purpose: strobe and pin checks on mlb_top
// Assumes: single clock domain
// Notes: bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module mlb_top_props (
	input wire       i_clk_sys,
	input wire       i_reset_n,
	input wire       i_cpu_req,
	input wire       i_cpu_write,
	input wire       o_busy,
	input wire       o_cpu_done,
	input wire       o_rd_n,
	input wire       o_wr_n,
	input wire       o_addr_latch_strobe,
	input wire       o_mux_addr_data_low_oe,
	input wire [7:0] o_addr_mid_byte
);
	// =========================================
	// properties
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	strobe_excl_a: assert property (o_rd_n || o_wr_n) else $error("rd and wr low together");
	wr_drives_a: assert property (!o_wr_n |-> o_mux_addr_data_low_oe) else $error("wr no drive");
	rd_released_a: assert property (!o_rd_n |-> !o_mux_addr_data_low_oe) else $error("rd drive");
	internal_quiet_a: assert property ((i_cpu_req && !o_busy) ##1 !o_busy |-> o_cpu_done
		&& o_rd_n && o_wr_n && !o_addr_latch_strobe && $stable(o_addr_mid_byte))
		else $error("internal access moved pins");
	strobe_pulse_a: assert property ($rose(o_addr_latch_strobe) |=> !o_addr_latch_strobe)
		else $error("strobe too long");
	rd_cause_a: assert property ($fell(o_rd_n) |-> $past(o_addr_latch_strobe)
		&& $past(i_cpu_req && !i_cpu_write, 2)) else $error("rd without read");
	wr_cause_a: assert property ($fell(o_wr_n) |-> $past(o_addr_latch_strobe)
		&& $past(i_cpu_req && i_cpu_write, 2)) else $error("wr without write");
	rd_end_a: assert property ($rose(o_rd_n) |-> o_cpu_done) else $error("rd end no done");
	busy_start_a: assert property ($rose(o_busy) |-> o_addr_latch_strobe && !o_cpu_done)
		else $error("busy without strobe");
	busy_end_a: assert property ($fell(o_busy) |-> o_cpu_done && o_rd_n && o_wr_n)
		else $error("busy end without done");
endmodule
`default_nettype wire

/* File: tb/mlb_ext_mem.sv */
// Purpose: external byte memory on the multiplexed pins
// Assumes: low address byte latched while strobe high
// Notes: released bus shows inverse of last read byte
`timescale 1ns/1ns
`default_nettype none
module mlb_ext_mem (
	input  wire       i_clk_sys,
	input  wire       i_strobe,
	input  wire       i_rd_n,
	input  wire       i_wr_n,
	input  wire [7:0] i_pins,
	output wire [7:0] o_pins
);
	reg [7:0] mem [0:255];
	reg [7:0] lat_r;
	reg [7:0] last_r = 8'h00;
	always @(posedge i_clk_sys) begin
		if (i_strobe) lat_r <= i_pins;
		if (!i_wr_n) mem[lat_r] <= i_pins;
		if (!i_rd_n) last_r <= o_pins;
	end
	assign o_pins = !i_rd_n ? mem[lat_r] : ~last_r;
endmodule
`default_nettype wire

/* File: tb/multiplexed_local_bus_strobes_tb.sv */
// Purpose: bench for mlb_top
// Assumes: wait code 0 for map tests
// Notes: pins resolved from output enable
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module multiplexed_local_bus_strobes_tb;
	reg        i_clk_sys = 1'b0;
	reg        i_reset_n = 1'b0;
	reg  [3:0] i_reg_addr = 4'h0;
	reg  [7:0] i_reg_wdata = 8'h00;
	reg        i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_rom_big = 1'b0, i_wait_n = 1'b1;
	reg        i_cpu_req = 1'b0, i_cpu_write = 1'b0;
	reg [19:0] i_cpu_addr = 20'h00000;
	reg  [7:0] i_cpu_wdata = 8'h00;
	wire [7:0] o_reg_rdata, o_cpu_rdata, pins_out, pins_ext, pins_in, o_addr_mid_byte;
	wire [3:0] o_addr_top_nibble;
	wire       o_busy, o_cpu_done, o_cpu_ext, o_rd_n, o_wr_n, strobe, port, oe;
	int        err_total = 0, checks = 0, cyc = 0, tick = 0, i;
	reg [31:0] tab [0:8];
	assign pins_in = oe ? pins_out : pins_ext;
	mlb_top dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_rom_big(i_rom_big), .i_cpu_req(i_cpu_req),
		.i_cpu_write(i_cpu_write), .i_cpu_addr(i_cpu_addr), .i_cpu_wdata(i_cpu_wdata),
		.o_busy(o_busy), .o_cpu_done(o_cpu_done), .o_cpu_ext(o_cpu_ext),
		.o_cpu_rdata(o_cpu_rdata), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
		.o_addr_latch_strobe(strobe), .i_wait_n(i_wait_n), .o_wait_pin_is_port(port),
		.o_mux_addr_data_low_out(pins_out), .o_mux_addr_data_low_oe(oe),
		.i_mux_addr_data_low_in(pins_in), .o_addr_mid_byte(o_addr_mid_byte),
		.o_addr_top_nibble(o_addr_top_nibble));
	mlb_ext_mem u_mem (.i_clk_sys(i_clk_sys), .i_strobe(strobe), .i_rd_n(o_rd_n),
		.i_wr_n(o_wr_n), .i_pins(pins_out), .o_pins(pins_ext));
	always #5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		tick++;
		if (tick == 3000) begin err_total++; give_verdict; end
	end
	// =========================================
	// tasks
	task reg_wr(input [3:0] a, input [7:0] d);
		@(posedge i_clk_sys) begin i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d; end
		@(posedge i_clk_sys) i_reg_wr <= 1'b0;
	endtask
	task reg_rd(input [3:0] a, input [7:0] e);
		@(posedge i_clk_sys) begin i_reg_rd <= 1'b1; i_reg_addr <= a; end
		@(posedge i_clk_sys) i_reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, o_reg_rdata)
	endtask
	task cpu(input w, input [19:0] a, input [7:0] d);
		@(posedge i_clk_sys) begin
			i_cpu_req <= 1'b1; i_cpu_write <= w; i_cpu_addr <= a; i_cpu_wdata <= d;
		end
		@(posedge i_clk_sys) i_cpu_req <= 1'b0;
		cyc = 1;
		#1;
		while (o_cpu_done !== 1'b1 && cyc < 60) begin @(posedge i_clk_sys); #1; cyc++; end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// =========================================
	// tests
	initial begin
		tab = '{32'h00030000, 32'h10118000, 32'h01118000, 32'h0010e000, 32'h1010ffd5,
			32'h101fe000, 32'h005fe000, 32'h0050ffd5, 32'h10254321};
		repeat (6) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		reg_rd(4'h0, 8'h00);
		reg_rd(4'h1, 8'h02);
		reg_rd(4'h2, 8'h01);
		reg_rd(4'hf, 8'h00);
		reg_wr(4'h0, 8'hff);
		reg_rd(4'h0, 8'h0f);
		`CHK("wait_port", 1'b1, port)
		$display("registers done");
		reg_wr(4'h1, 8'h00);
		for (i = 0; i < 9; i++) begin
			reg_wr(4'h0, {4'h0, tab[i][23:20]});
			i_rom_big <= tab[i][24];
			cpu(1'b0, tab[i][19:0], 8'h00);
			`CHK("ext", tab[i][28], o_cpu_ext)
			`CHK("cycles", tab[i][28] ? 4 : 1, cyc)
		end
		`CHK("top", 4'h5, o_addr_top_nibble)
		$display("map done");
		reg_wr(4'h0, 8'h01);
		for (i = 0; i < 3; i++) begin
			reg_wr(4'h1, i[7:0]);
			cpu(1'b1, 20'h54321, 8'ha0 + i[7:0]);
			`CHK("wr_cycles", 4 + i, cyc)
			`CHK("mid", 8'h43, o_addr_mid_byte)
			`CHK("top", 4'h1, o_addr_top_nibble)
			cpu(1'b0, 20'h54321, 8'h00);
			`CHK("rdata", 8'ha0 + i[7:0], o_cpu_rdata)
		end
		reg_wr(4'h1, 8'h03);
		i_wait_n <= 1'b0;
		cpu(1'b0, 20'h0e000, 8'h00);
		`CHK("int_cycles", 1, cyc)
		`CHK("int_pins", 8'h43, o_addr_mid_byte)
		`CHK("wait_port", 1'b0, port)
		fork
			cpu(1'b0, 20'h54321, 8'h00);
			begin repeat (9) @(posedge i_clk_sys); i_wait_n <= 1'b1; end
		join
		`CHK("stretch", 1'b1, cyc > 8)
		`CHK("rdata", 8'ha2, o_cpu_rdata)
		$display("wait done");
		give_verdict;
	end
endmodule
bind mlb_top mlb_top_props u_props (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.i_cpu_req(i_cpu_req), .i_cpu_write(i_cpu_write), .o_busy(o_busy),
	.o_cpu_done(o_cpu_done), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
	.o_addr_latch_strobe(o_addr_latch_strobe), .o_addr_mid_byte(o_addr_mid_byte),
	.o_mux_addr_data_low_oe(o_mux_addr_data_low_oe));
`default_nettype wire
